// File: hw/nnse_exec.v
// The strobed register port and the address map were chosen for this implementation.
`timescale 1ns/100ps
`include "nnse_consts.vh"
module nnse_exec (
    input  wire        clk,
    input  wire        rst,
    input  wire [15:0] instrWord,
    input  wire        extendedMode,
    input  wire [5:0]  bankSelectReg,
    input  wire [11:0] indexBase,
    input  wire [7:0]  memReadData,
    input  wire [4:0]  statusIn,
    output reg  [11:0] memAddr,
    output reg         memReadEn,
    output reg         memWriteEn,
    output reg  [7:0]  memWriteData,
    output reg  [4:0]  statusOut,
    output reg         statusWriteEn,
    output reg         stackPop,
    output reg         idleSeen,
    output reg  [3:0]  phase
);
    // phase codes of the four-step instruction cycle, one-hot
    localparam [3:0] PH_DECODE  = `NNSE_Q1;
    localparam [3:0] PH_READ    = `NNSE_Q2;
    localparam [3:0] PH_COMPUTE = `NNSE_Q3;
    localparam [3:0] PH_WRITE   = `NNSE_Q4;

    reg  [3:0]  next_phase;
    reg         isNeg;
    reg         isDrop;
    reg  [7:0]  operand;
    reg  [7:0]  result;
    reg  [4:0]  flags;
    reg  [11:0] next_addr;
    wire [7:0]  aluResult;
    wire [4:0]  aluFlags;
    wire [7:0]  fileAddr;
    wire        accessSel;
    wire        decNeg;
    wire        decDrop;
    wire        decIdle;
    wire        inDecode;
    wire        inRead;
    wire        inCompute;
    wire        inWrite;
    wire        useIndexed;
    wire        useLowAccess;
    wire [11:0] bankAddr;
    wire [11:0] indexAddr;
    wire [11:0] lowAccessAddr;
    wire [11:0] highAccessAddr;

    // instruction word fields
    assign fileAddr  = instrWord[7:0];
    assign accessSel = instrWord[8];

    // decode of the three handled words
    assign decNeg  = (instrWord[15:9] == `NNSE_NEG_OPC);
    assign decDrop = (instrWord == `NNSE_DROP_WORD);
    assign decIdle = (instrWord == `NNSE_IDLE_WORD) ||
                     (instrWord[15:12] == `NNSE_IDLE_NIBBLE);

    // one flag per phase of the instruction cycle
    assign inDecode  = (phase == PH_DECODE);
    assign inRead    = (phase == PH_READ);
    assign inCompute = (phase == PH_COMPUTE);
    assign inWrite   = (phase == PH_WRITE);

    // candidate addresses, one per addressing mode
    assign bankAddr       = {bankSelectReg[3:0], fileAddr};
    assign indexAddr      = indexBase + {4'h0, fileAddr};
    assign lowAccessAddr  = {`NNSE_ACC_LOW_PAGE, fileAddr};
    assign highAccessAddr = {`NNSE_ACC_HIGH_PAGE, fileAddr};

    // indexed only with the extended set; low access below the split
    assign useIndexed   = ~accessSel && extendedMode &&
                          (fileAddr <= `NNSE_IDX_LIMIT);
    assign useLowAccess = (fileAddr < `NNSE_ACC_SPLIT);

    // effective address selection
    always @* begin
        if (accessSel) begin
            next_addr = bankAddr;
        end else if (useIndexed) begin
            next_addr = indexAddr;
        end else if (useLowAccess) begin
            next_addr = lowAccessAddr;
        end else begin
            next_addr = highAccessAddr;
        end
    end

    // negate datapath
    nnse_negate_alu nnse_negate_alu_i (
        .operand (operand),
        .result  (aluResult),
        .flags   (aluFlags)
    );

    // quadrature phase sequencer
    always @* begin
        case (phase)
            PH_DECODE:  next_phase = PH_READ;
            PH_READ:    next_phase = PH_COMPUTE;
            PH_COMPUTE: next_phase = PH_WRITE;
            PH_WRITE:   next_phase = PH_DECODE;
            default:    next_phase = PH_DECODE;
        endcase
    end

    // phase register, a one-hot ring
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            phase <= PH_DECODE;
        end else begin
            phase <= next_phase;
        end
    end

    // decode latch, taken once per cycle at the end of the decode phase
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            isNeg    <= 1'b0;
            isDrop   <= 1'b0;
            idleSeen <= 1'b0;
        end else if (inDecode) begin
            isNeg    <= decNeg;
            isDrop   <= decDrop;
            idleSeen <= decIdle;
        end
    end

    // effective address and the read request for the operand fetch
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            memAddr   <= 12'h000;
            memReadEn <= 1'b0;
        end else if (inDecode) begin
            memAddr   <= next_addr;
            memReadEn <= decNeg;
        end else begin
            memReadEn <= 1'b0;
        end
    end

    // operand capture while the read is presented
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            operand <= 8'h00;
        end else if (inRead && isNeg) begin
            operand <= memReadData;
        end
    end

    // result and flags latched in the compute phase
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            result <= 8'h00;
            flags  <= 5'h00;
        end else if (inCompute && isNeg) begin
            result <= aluResult;
            flags  <= aluFlags;
        end
    end

    // pop strobe to the return stack, one cycle wide
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            stackPop <= 1'b0;
        end else begin
            stackPop <= inCompute && isDrop;
        end
    end

    // write-back strobe and data, shown in the cycle after the write phase
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            memWriteEn   <= 1'b0;
            memWriteData <= 8'h00;
        end else if (inWrite && isNeg) begin
            memWriteEn   <= 1'b1;
            memWriteData <= result;
        end else begin
            memWriteEn   <= 1'b0;
        end
    end

    // status write strobe; only a negate raises it
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            statusWriteEn <= 1'b0;
        end else begin
            statusWriteEn <= inWrite && isNeg;
        end
    end

    // status value; other words pass the current bits through unchanged
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            statusOut <= 5'h00;
        end else if (inWrite) begin
            if (isNeg) begin
                statusOut <= flags;
            end else begin
                statusOut <= statusIn;
            end
        end
    end
endmodule

// File: hw/nnse_consts.vh
`ifndef NNSE_CONSTS_VH
`define NNSE_CONSTS_VH
// instruction encodings
`define NNSE_NEG_OPC       7'h36
`define NNSE_DROP_WORD     16'h0006
`define NNSE_IDLE_WORD     16'h0000
`define NNSE_IDLE_NIBBLE   4'hF
// extended-mode literal offset limit
`define NNSE_IDX_LIMIT     8'h5F
// access bank split point and upper bank
`define NNSE_ACC_SPLIT     8'h60
`define NNSE_ACC_HIGH_BANK 6'h3F
`define NNSE_ACC_LOW_PAGE  4'h0
`define NNSE_ACC_HIGH_PAGE 4'hF
// status bit positions
`define NNSE_ST_C          0
`define NNSE_ST_DC         1
`define NNSE_ST_Z          2
`define NNSE_ST_OV         3
`define NNSE_ST_N          4
// quadrature phase codes, one-hot
`define NNSE_Q1            4'h1
`define NNSE_Q2            4'h2
`define NNSE_Q3            4'h4
`define NNSE_Q4            4'h8
`endif

// File: hw/nnse_negate_alu.v
`timescale 1ns/100ps
`include "nnse_consts.vh"
// two's complement negate with flag generation
module nnse_negate_alu (
    input  wire [7:0] operand,
    output wire [7:0] result,
    output wire [4:0] flags
);
    wire [8:0] sum;
    wire [4:0] lowSum;

    // invert and add one, keeping carries out of bit 3 and bit 7
    assign sum    = {1'b0, ~operand} + 9'h001;
    assign lowSum = {1'b0, ~operand[3:0]} + 5'h01;
    assign result = sum[7:0];

    // flags of the add-one
    assign flags[`NNSE_ST_C]  = sum[8];
    assign flags[`NNSE_ST_DC] = lowSum[4];
    assign flags[`NNSE_ST_Z]  = (sum[7:0] == 8'h00);
    // 00h and 80h negate to themselves; of the negative operands only 80h gives a negative result from the add-one
    assign flags[`NNSE_ST_OV] = operand[7] & sum[7];
    assign flags[`NNSE_ST_N]  = sum[7];
endmodule

// File: testbench/nnse_exec_monitor.sv
`timescale 1ns/100ps
// phase ring, result timing and stack pop checks
module nnse_exec_monitor (
    input logic        clk,
    input logic        rst,
    input logic [15:0] instrWord,
    input logic [7:0]  memReadData,
    input logic        memReadEn,
    input logic        memWriteEn,
    input logic [7:0]  memWriteData,
    input logic        statusWriteEn,
    input logic        stackPop,
    input logic [3:0]  phase
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // decode-time views of the word
    wire isNeg = phase == 4'h1 && instrWord[15:9] == 7'h36;
    wire isDrop = phase == 4'h1 && instrWord == 16'h0006;
    wire isIdle = phase == 4'h1 && (instrWord == 16'h0000
                  || instrWord[15:12] == 4'hF);
    phase_ring_a: assert property (1 |=> phase == {$past(phase[2:0]),
        $past(phase[3])}) else $error("phase not rotating");
    neg_timing_a: assert property (isNeg |=> memReadEn ##3
        (memWriteEn && statusWriteEn)) else $error("negate timing");
    neg_value_a: assert property (memReadEn |-> ##3
        memWriteData == 8'h00 - $past(memReadData, 3))
        else $error("negate value wrong");
    drop_pop_a: assert property (isDrop |-> ##3 stackPop)
        else $error("drop did not pop");
    pop_quiet_a: assert property (stackPop |-> phase == 4'h8
        && !statusWriteEn && !memWriteEn) else $error("pop side effect");
    write_pair_a: assert property (memWriteEn |-> statusWriteEn
        && phase == 4'h1) else $error("write and flags split");
    idle_quiet_a: assert property (isIdle |=> !memReadEn
        ##1 !stackPop[*2] ##1 !memWriteEn) else $error("idle acted");
    pop_cause_a: assert property (stackPop |->
        $past(instrWord, 3) == 16'h0006) else $error("stray pop");
    cover property (isNeg);
    cover property (isDrop);
    cover property (isIdle);
endmodule

// File: testbench/nnse_exec_test.sv
`timescale 1ns/100ps
// drives instruction words and checks memory, flag and stack results
module nnse_exec_test;
    logic        clk, rst, extendedMode, memReadEn, memWriteEn;
    logic        statusWriteEn, stackPop, idleSeen;
    logic [15:0] instrWord;
    logic [7:0]  memReadData, memWriteData;
    logic [11:0] memAddr;
    logic [4:0]  statusOut;
    logic [3:0]  phase;
    int          nMismatch = 0, nTests = 0, cyc = 0;
    nnse_exec nnse_exec_i (.clk(clk), .rst(rst), .instrWord(instrWord),
        .extendedMode(extendedMode), .bankSelectReg(6'h35),
        .indexBase(12'h100), .memReadData(memReadData), .statusIn(5'h00),
        .memAddr(memAddr), .memReadEn(memReadEn), .memWriteEn(memWriteEn),
        .memWriteData(memWriteData), .statusOut(statusOut),
        .statusWriteEn(statusWriteEn), .stackPop(stackPop),
        .idleSeen(idleSeen), .phase(phase));
    initial begin
        clk = 0;
        forever #12.5 clk = ~clk;
    end
    // hang guard
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 400) begin
            nMismatch++;
            endOfTest();
        end
    end
    task chk(input string what, input logic [11:0] exp, got);
        nTests++;
        if (got !== exp) begin
            nMismatch++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task endOfTest;
        $display("checks %0d mismatches %0d", nTests, nMismatch);
        if (nMismatch == 0 && nTests > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    // issue one word just before a decode edge, check after write-back
    task exec(input logic [15:0] w, input logic [7:0] d, input logic x,
              input logic [11:0] ea);
        logic       neg, pop, idl;
        logic [7:0] r;
        neg = w[15:9] == 7'h36;
        idl = w == 16'h0000 || w[15:12] == 4'hF;
        r = 8'h00 - d;
        // settle into the write phase, then drive at its closing edge
        do begin
            @(posedge clk);
            #1;
        end while (phase !== 4'h8);
        @(posedge clk);
        instrWord <= w;
        memReadData <= d;
        extendedMode <= x;
        @(posedge clk);
        instrWord <= 16'h0000;
        repeat (2) @(posedge clk);
        #1 pop = stackPop;
        @(posedge clk);
        #1 chk("pop", {11'h0, w == 16'h0006}, {11'h0, pop});
        chk("write", {11'h0, neg}, {11'h0, memWriteEn});
        chk("stwr", {11'h0, neg}, {11'h0, statusWriteEn});
        chk("idle", {11'h0, idl}, {11'h0, idleSeen});
        if (neg) begin
            chk("addr", ea, memAddr);
            chk("data", {4'h0, r}, {4'h0, memWriteData});
            chk("flags", {7'h0, r[7], d == 8'h80, r == 8'h00,
                d[3:0] == 4'h0, d == 8'h00}, {7'h0, statusOut});
        end
    endtask
    initial begin
        rst = 1;
        instrWord = 16'h0000;
        memReadData = 8'h00;
        extendedMode = 0;
        repeat (5) @(posedge clk);
        rst <= 0;
        exec(16'h6D3A, 8'h3A, 1'h0, 12'h53A);
        exec(16'h6C70, 8'h00, 1'h0, 12'hF70);
        exec(16'h6C20, 8'h80, 1'h0, 12'h020);
        exec(16'h6C20, 8'h08, 1'h1, 12'h120);
        exec(16'h6C60, 8'h01, 1'h1, 12'hF60);
        exec(16'h0000, 8'h55, 1'h0, 12'h000);
        exec(16'hFABC, 8'h55, 1'h0, 12'h000);
        exec(16'h0006, 8'h55, 1'h0, 12'h000);
        exec(16'h6D3A, 8'hC6, 1'h0, 12'h53A);
        endOfTest();
    end
endmodule
bind nnse_exec nnse_exec_monitor nnse_exec_monitor_i (.clk(clk), .rst(rst),
    .instrWord(instrWord), .memReadData(memReadData),
    .memReadEn(memReadEn), .memWriteEn(memWriteEn),
    .memWriteData(memWriteData), .statusWriteEn(statusWriteEn),
    .stackPop(stackPop), .phase(phase));
